// ### tcc_channel.sv
`timescale 1ns/1ps
module tcc_channel #(
    parameter int CNT_W = 16,
    parameter int CHANNEL_INDEX = 1
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_timer_input_pin,
    input wire logic i_neighbour_filtered_input,
    input wire logic [CNT_W-1:0] i_counter_value,
    input wire logic [CNT_W-1:0] i_reload_value,
    input wire logic i_count_down,
    input wire logic [1:0] i_alignment_select,
    input wire logic i_update_event,
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic o_filtered_timer_input,
    output logic o_trigger_edge,
    output logic o_compare_reference_wave,
    output logic o_channel_out,
    output logic o_irq,
    output logic o_dma_req
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int CTL_W = tcc_pkg::CTL_WIDTH;
    typedef struct packed {
        logic [CTL_W-1:0] ctrl;
        logic event_flag;
        logic over_flag;
        logic [CNT_W-1:0] preload;
        logic [CNT_W-1:0] shadow;
        logic xfer_pending;
        logic [3:0] flt_cnt;
        logic [3:0] smp_cnt;
        logic filtered;
        logic sel_prev;
        logic [2:0] div_cnt;
        logic match_prev;
        logic ref_level;
        logic out_level;
        logic trig;
        logic irq;
        logic dma;
        logic wait_n;
        logic [31:0] rdata;
    } tcc_state_t;

    tcc_state_t st_reg;
    tcc_state_t st_next;

    logic [3:0] flt_code;
    logic [3:0] flt_len;
    logic smp_tick;
    logic sel_in;
    logic edge_sel;
    logic div_event;
    logic capture;
    logic match;
    logic cmp_event;
    logic pwm_high;
    logic [2:0] div_mask;
    logic bus_done;
    logic [2:0] mode;
    logic [1:0] dir;
    logic out_mode;

    // ------------------------------------------------------------
    // input stage and compare decode
    // ------------------------------------------------------------
    always_comb begin
        dir = st_reg.ctrl[tcc_pkg::CTL_DIR_LSB +: 2];
        mode = st_reg.ctrl[tcc_pkg::CTL_MODE_LSB +: 3];
        out_mode = (dir == tcc_pkg::DIR_OUTPUT);
        flt_code = st_reg.ctrl[tcc_pkg::CTL_FLT_LSB +: 4];
        // filter length: codes 0..3 give 1,2,4,8 samples; higher codes 8 at slower rate [R10]
        if (flt_code <= tcc_pkg::FLT_LAST_SHORT) begin
            flt_len = 4'(4'h1 << flt_code[1:0]);
            smp_tick = 1'b1;
        end else begin
            flt_len = tcc_pkg::FLT_LONG_LEN;
            smp_tick = (st_reg.smp_cnt >= 4'(flt_code - tcc_pkg::FLT_BASE_DIV));
        end
        // capture source mux [R9] [R14]
        sel_in = (dir == tcc_pkg::DIR_NEIGHBOUR) ? i_neighbour_filtered_input : st_reg.filtered;
        // polarity selected edge [R11]
        edge_sel = st_reg.ctrl[tcc_pkg::CTL_POLARITY] ? (st_reg.sel_prev & ~sel_in)
                                                       : (~st_reg.sel_prev & sel_in);
        // divider: 00 every edge, then every 2, 4, 8 [R2] [R12]
        div_mask = 3'(4'h7 >> (2'h3 - st_reg.ctrl[tcc_pkg::CTL_DIV_LSB +: 2]));
        div_event = edge_sel && ((st_reg.div_cnt & div_mask) == div_mask);
        capture = div_event && st_reg.ctrl[tcc_pkg::CTL_ENABLE]
                  && (dir == tcc_pkg::DIR_OWN || dir == tcc_pkg::DIR_NEIGHBOUR); // [R12]
        // only the shadow copy meets the counter [R5]
        match = out_mode && (i_counter_value == st_reg.shadow);
        // flag on match rising, gated by alignment in pwm modes [R21]
        cmp_event = match && !st_reg.match_prev;
        if (mode[2:1] == 2'h3) begin
            if (i_alignment_select == tcc_pkg::ALIGN_DOWN) begin
                cmp_event = cmp_event && i_count_down;
            end else if (i_alignment_select == tcc_pkg::ALIGN_UP) begin
                cmp_event = cmp_event && !i_count_down;
            end
        end
        // pwm 1 level: up high below value, down low above value [R23]
        pwm_high = i_count_down ? (i_counter_value <= st_reg.shadow) : (i_counter_value < st_reg.shadow);
        bus_done = (i_read || i_write) && st_reg.wait_n;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.trig = 1'b0;
        st_next.dma = 1'b0;
        // digital filter: new level accepted after flt_len equal samples [R1] [R10]
        st_next.smp_cnt = smp_tick ? 4'h0 : 4'(st_reg.smp_cnt + 4'h1);
        if (smp_tick) begin
            if (i_timer_input_pin == st_reg.filtered) begin
                st_next.flt_cnt = 4'h0;
            end else if (4'(st_reg.flt_cnt + 4'h1) >= flt_len) begin
                st_next.filtered = i_timer_input_pin;
                st_next.flt_cnt = 4'h0;
            end else begin
                st_next.flt_cnt = 4'(st_reg.flt_cnt + 4'h1);
            end
        end
        st_next.sel_prev = sel_in;
        // trigger edge offered to slave controller, channels 1 and 2 only [R1] [R15]
        if (CHANNEL_INDEX == 1 || CHANNEL_INDEX == 2) begin
            st_next.trig = st_reg.ctrl[tcc_pkg::CTL_POLARITY] ? (st_reg.filtered & ~st_next.filtered)
                                                              : (~st_reg.filtered & st_next.filtered);
        end
        if (edge_sel && st_reg.ctrl[tcc_pkg::CTL_ENABLE]) begin
            st_next.div_cnt = 3'(st_reg.div_cnt + 3'h1);
        end
        if (!st_reg.ctrl[tcc_pkg::CTL_ENABLE] || out_mode) begin
            st_next.div_cnt = 3'h0;
        end
        st_next.match_prev = match;

        // ---- register bus: one wait cycle, then completion ----
        st_next.wait_n = 1'b0;
        if ((i_read || i_write) && !st_reg.wait_n) begin
            st_next.wait_n = 1'b1;
        end
        if (i_read && !st_reg.wait_n) begin
            unique case (i_address)
                tcc_pkg::ADDR_CTRL: st_next.rdata = 32'(st_reg.ctrl);
                tcc_pkg::ADDR_STS: st_next.rdata = {30'h0, st_reg.over_flag, st_reg.event_flag};
                tcc_pkg::ADDR_VALUE: st_next.rdata = 32'(st_reg.preload); // [R4]
                default: st_next.rdata = 32'h0;
            endcase
        end
        if (bus_done && i_write) begin
            unique case (i_address)
                tcc_pkg::ADDR_CTRL: st_next.ctrl = i_writedata[CTL_W-1:0];
                tcc_pkg::ADDR_STS: begin
                    if (!i_writedata[tcc_pkg::STS_EVENT]) begin
                        st_next.event_flag = 1'b0; // [R7]
                    end
                    if (!i_writedata[tcc_pkg::STS_OVER]) begin
                        st_next.over_flag = 1'b0; // [R8]
                    end
                end
                tcc_pkg::ADDR_VALUE: st_next.preload = i_writedata[CNT_W-1:0]; // [R4]
                default: ;
            endcase
        end
        if (bus_done && i_read && i_address == tcc_pkg::ADDR_VALUE) begin
            st_next.event_flag = 1'b0; // [R7]
        end

        // ---- capture: shadow first, preload one cycle later ----
        if (st_reg.xfer_pending) begin
            st_next.preload = st_reg.shadow; // [R4]
        end
        st_next.xfer_pending = capture;
        if (capture) begin
            st_next.shadow = i_counter_value; // [R6]
            if (st_reg.event_flag) begin
                st_next.over_flag = 1'b1; // [R8]
            end
            st_next.event_flag = 1'b1; // [R6]
            st_next.dma = st_reg.ctrl[tcc_pkg::CTL_DMA_EN]; // [R13]
        end

        // ---- compare: preload to shadow, immediate or at update ----
        if (out_mode) begin
            if (!st_reg.ctrl[tcc_pkg::CTL_PRELOAD] || i_update_event) begin
                st_next.shadow = st_reg.preload; // [R5] [R20] [R22]
            end
            if (cmp_event) begin
                st_next.event_flag = 1'b1; // [R17] [R19]
            end
            // dma from compare match or from update event by select [R19]
            if (st_reg.ctrl[tcc_pkg::CTL_DMA_EN]) begin
                st_next.dma = st_reg.ctrl[tcc_pkg::CTL_DMA_SEL] ? i_update_event : cmp_event; // [R13]
            end
            unique case (mode)
                tcc_pkg::MODE_FROZEN: ; // [R18]
                tcc_pkg::MODE_ACTIVE: if (cmp_event) st_next.ref_level = 1'b1; // [R24]
                tcc_pkg::MODE_INACTIVE: if (cmp_event) st_next.ref_level = 1'b0; // [R18]
                tcc_pkg::MODE_TOGGLE: if (cmp_event) st_next.ref_level = ~st_reg.ref_level; // [R18]
                tcc_pkg::MODE_FORCE_LOW: st_next.ref_level = 1'b0; // [R16] [R17]
                tcc_pkg::MODE_FORCE_HIGH: st_next.ref_level = 1'b1; // [R16] [R17]
                tcc_pkg::MODE_PWM1: st_next.ref_level = pwm_high; // [R21] [R23]
                tcc_pkg::MODE_PWM2: st_next.ref_level = ~pwm_high; // [R21]
            endcase
        end
        // active high reference; polarity only at the pin stage [R3]
        st_next.out_level = (st_next.ref_level ^ st_next.ctrl[tcc_pkg::CTL_POLARITY])
                            & st_next.ctrl[tcc_pkg::CTL_ENABLE]
                            & (st_next.ctrl[tcc_pkg::CTL_DIR_LSB +: 2] == tcc_pkg::DIR_OUTPUT);
        st_next.irq = st_next.event_flag & st_next.ctrl[tcc_pkg::CTL_IRQ_EN]; // [R13]
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------
    assign o_readdata = st_reg.rdata;
    assign o_waitrequest = ~st_reg.wait_n;
    assign o_filtered_timer_input = st_reg.filtered;
    assign o_trigger_edge = st_reg.trig;
    assign o_compare_reference_wave = st_reg.ref_level;
    assign o_channel_out = st_reg.out_level;
    assign o_irq = st_reg.irq;
    assign o_dma_req = st_reg.dma;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    capture_sets_flag_a: assert property (capture |=> st_reg.event_flag && st_reg.shadow == $past(i_counter_value)) // [R6]
        else $error("capture did not latch counter and set flag");
    shadow_to_preload_a: assert property (capture |-> ##2 st_reg.preload == $past(i_counter_value, 2)) // [R4]
        else $error("captured value not moved to preload copy");
    overcapture_set_a: assert property (capture && st_reg.event_flag |=> st_reg.over_flag) // [R8]
        else $error("overcapture not flagged");
    overcapture_hold_a: assert property (st_reg.over_flag && !(bus_done && i_write) |=> st_reg.over_flag) // [R8]
        else $error("overcapture cleared without write");
    read_clears_flag_a: assert property (bus_done && i_read && i_address == tcc_pkg::ADDR_VALUE
        && !capture && !cmp_event |=> !st_reg.event_flag) // [R7]
        else $error("value read did not clear flag");
    no_capture_off_a: assert property (!out_mode && !st_reg.ctrl[tcc_pkg::CTL_ENABLE] // [R12]
        |=> st_reg.shadow == $past(st_reg.shadow))
        else $error("capture while disabled");
    force_high_a: assert property (out_mode && mode == tcc_pkg::MODE_FORCE_HIGH |=> st_reg.ref_level) // [R16]
        else $error("forced high not applied");
    force_low_a: assert property (out_mode && mode == tcc_pkg::MODE_FORCE_LOW |=> !st_reg.ref_level) // [R16]
        else $error("forced low not applied");
    toggle_match_a: assert property (out_mode && mode == tcc_pkg::MODE_TOGGLE && cmp_event
        |=> st_reg.ref_level != $past(st_reg.ref_level)) // [R18]
        else $error("toggle on match missing");
    pwm1_level_a: assert property (out_mode && mode == tcc_pkg::MODE_PWM1 && !i_count_down
        |=> st_reg.ref_level == ($past(i_counter_value) < $past(st_reg.shadow))) // [R23]
        else $error("pwm 1 level wrong");
    polarity_out_a: assert property (st_reg.ctrl[tcc_pkg::CTL_ENABLE] && out_mode
        |-> o_channel_out == (st_reg.ref_level ^ st_reg.ctrl[tcc_pkg::CTL_POLARITY])) // [R3]
        else $error("output polarity stage wrong");
    irq_gate_a: assert property (o_irq |-> st_reg.ctrl[tcc_pkg::CTL_IRQ_EN] && st_reg.event_flag) // [R13]
        else $error("interrupt without enable");
    dma_gate_a: assert property (o_dma_req |-> $past(st_reg.ctrl[tcc_pkg::CTL_DMA_EN])) // [R13]
        else $error("dma request without enable");
    preload_hold_a: assert property (out_mode && st_reg.ctrl[tcc_pkg::CTL_PRELOAD] && !i_update_event
        |=> st_reg.shadow == $past(st_reg.shadow)) // [R20]
        else $error("shadow changed without update");
    bus_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest) // [R4]
        else $error("bus answer late");

    capture_cov: cover property (capture ##[1:50] capture);
    force_cov: cover property (out_mode && mode == tcc_pkg::MODE_FORCE_HIGH && cmp_event);
    pwm_cov: cover property (out_mode && mode == tcc_pkg::MODE_PWM1 && st_reg.ref_level ##1 !st_reg.ref_level);
    read_cov: cover property (bus_done && i_read && i_address == tcc_pkg::ADDR_VALUE && st_reg.event_flag);
endmodule // tcc_channel

// ### tcc_channel_tb_top.sv
`timescale 1ns/1ps
module tcc_channel_tb_top;
    // ------------------------------------------------------------
    // signals, partner and design
    // ------------------------------------------------------------
    typedef struct {logic [2:0] mode; logic pol; logic ref_exp;} tcc_row_t;
    logic i_mclk, i_nrst, lvl, nb_lvl, upd, rd, wr, pin, nb;
    logic waitreq, filt, trig, refw, chout, irq, dma;
    logic [7:0] glen;
    logic [15:0] cnt;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, d;
    int error_cnt = 0, cmp_count = 0, dma_cnt = 0, trig_cnt = 0, cyc = 0, k, t;
    tcc_row_t rows [8];
    tcc_signal_src src (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_level(lvl), .i_nb_level(nb_lvl),
        .i_glitch_len(glen), .o_timer_input_pin(pin), .o_neighbour_filtered(nb));
    tcc_channel dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_timer_input_pin(pin), .i_neighbour_filtered_input(nb),
        .i_counter_value(cnt), .i_reload_value(16'h00FF), .i_count_down(1'b0), .i_alignment_select(2'h0),
        .i_update_event(upd), .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
        .o_readdata(rdata), .o_waitrequest(waitreq), .o_filtered_timer_input(filt), .o_trigger_edge(trig),
        .o_compare_reference_wave(refw), .o_channel_out(chout), .o_irq(irq), .o_dma_req(dma));
    // clock
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    // pulse counters and hang guard
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (dma === 1'b1) dma_cnt <= dma_cnt + 1;
        if (trig === 1'b1) trig_cnt <= trig_cnt + 1;
        if (cyc == 6000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one avalon transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_mclk);
        addr <= a;
        wdata <= wd;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge i_mclk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        chk("waitrequest", 32'h0, {31'h0, waitreq});
        d = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    task automatic lvl_to(input logic v);
        @(posedge i_mclk) lvl <= v;
        settle(20);
    endtask
    task automatic pulse_upd();
        @(posedge i_mclk) upd <= 1'b1;
        @(posedge i_mclk) upd <= 1'b0;
        settle(3);
    endtask
    // bits: dma, irq, enable, polarity, preload
    function automatic logic [31:0] ctl(input logic [1:0] dir, input logic [3:0] flt, input logic [2:0] mode,
        input logic [4:0] bits);
        ctl = 32'h0;
        ctl[tcc_pkg::CTL_DIR_LSB +: 2] = dir;
        ctl[tcc_pkg::CTL_FLT_LSB +: 4] = flt;
        ctl[tcc_pkg::CTL_MODE_LSB +: 3] = mode;
        ctl[tcc_pkg::CTL_PRELOAD +: 5] = bits;
    endfunction
    task automatic end_sim();
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {i_nrst, lvl, nb_lvl, upd, rd, wr, glen, cnt, addr, wdata} = '0;
        rows[0] = '{tcc_pkg::MODE_FORCE_LOW, 1'b0, 1'b0};
        rows[1] = '{tcc_pkg::MODE_ACTIVE, 1'b0, 1'b1};
        rows[2] = '{tcc_pkg::MODE_FROZEN, 1'b1, 1'b1};
        rows[3] = '{tcc_pkg::MODE_TOGGLE, 1'b0, 1'b0};
        rows[4] = '{tcc_pkg::MODE_TOGGLE, 1'b0, 1'b1};
        rows[5] = '{tcc_pkg::MODE_INACTIVE, 1'b1, 1'b0};
        rows[6] = '{tcc_pkg::MODE_FORCE_HIGH, 1'b1, 1'b1};
        rows[7] = '{tcc_pkg::MODE_FORCE_LOW, 1'b0, 1'b0};
        repeat (20) @(posedge i_mclk);
        chk("reset out", 32'h0, {31'h0, chout});
        @(posedge i_mclk) i_nrst <= 1'b1;
        rreg(tcc_pkg::ADDR_CTRL);
        chk("ctrl reset", {15'h0, tcc_pkg::CTL_RESET}, d);
        wreg(4'hC, 32'hFFFFFFFF);
        rreg(4'hC);
        chk("unmapped", 32'h0, d);
        // compare modes: match once per row, reference, pin, flag and requests
        for (int i = 0; i < 8; i++) begin
            @(posedge i_mclk) cnt <= 16'h0005;
            wreg(tcc_pkg::ADDR_VALUE, 32'h7);
            wreg(tcc_pkg::ADDR_CTRL, ctl(tcc_pkg::DIR_OUTPUT, 4'h0, rows[i].mode, {3'h7, rows[i].pol, 1'b0}));
            wreg(tcc_pkg::ADDR_STS, 32'h0);
            k = dma_cnt;
            @(posedge i_mclk) cnt <= 16'h0007;
            settle(4);
            chk("reference", {31'h0, rows[i].ref_exp}, {31'h0, refw});
            chk("pin", {31'h0, rows[i].ref_exp ^ rows[i].pol}, {31'h0, chout});
            chk("irq", 32'h1, {31'h0, irq});
            chk("dma", 32'(k + 1), 32'(dma_cnt));
            rreg(tcc_pkg::ADDR_STS);
            chk("match flag", 32'h1, {31'h0, d[0]});
        end
        // pwm with preload
        @(posedge i_mclk) cnt <= 16'h000F;
        wreg(tcc_pkg::ADDR_CTRL, ctl(tcc_pkg::DIR_OUTPUT, 4'h0, tcc_pkg::MODE_PWM1, 5'h05));
        wreg(tcc_pkg::ADDR_VALUE, 32'hA);
        pulse_upd();
        chk("pwm1 at or above", 32'h0, {31'h0, refw});
        wreg(tcc_pkg::ADDR_VALUE, 32'h14);
        settle(4);
        chk("preload held", 32'h0, {31'h0, refw});
        pulse_upd();
        chk("pwm1 below", 32'h1, {31'h0, refw});
        @(posedge i_mclk) cnt <= 16'h0019;
        settle(4);
        chk("pwm1 above", 32'h0, {31'h0, refw});
        wreg(tcc_pkg::ADDR_CTRL, ctl(tcc_pkg::DIR_OUTPUT, 4'h0, tcc_pkg::MODE_PWM2, 5'h05));
        settle(4);
        chk("pwm2 above", 32'h1, {31'h0, refw});
        // capture with filter, glitch first
        @(posedge i_mclk) cnt <= 16'h1234;
        wreg(tcc_pkg::ADDR_STS, 32'h0);
        wreg(tcc_pkg::ADDR_CTRL, ctl(tcc_pkg::DIR_OWN, tcc_pkg::FLT_LAST_SHORT, tcc_pkg::MODE_FROZEN, 5'h1C));
        k = dma_cnt;
        t = trig_cnt;
        @(posedge i_mclk) glen <= 8'h05;
        @(posedge i_mclk) glen <= 8'h00;
        settle(14);
        chk("glitch filtered", 32'h0, {31'h0, filt});
        lvl_to(1'b1);
        chk("filtered", 32'h1, {31'h0, filt});
        chk("trigger", 32'(t + 1), 32'(trig_cnt));
        chk("capture irq", 32'h1, {31'h0, irq});
        chk("capture dma", 32'(k + 1), 32'(dma_cnt));
        rreg(tcc_pkg::ADDR_VALUE);
        chk("captured", 32'h1234, d);
        rreg(tcc_pkg::ADDR_STS);
        chk("flag after read", 32'h0, d);
        // overcapture: two captures without a read
        lvl_to(1'b0);
        chk("falling ignored", 32'(t + 1), 32'(trig_cnt));
        lvl_to(1'b1);
        @(posedge i_mclk) cnt <= 16'h3333;
        lvl_to(1'b0);
        lvl_to(1'b1);
        rreg(tcc_pkg::ADDR_STS);
        chk("overcapture", 32'h3, d);
        rreg(tcc_pkg::ADDR_VALUE);
        chk("latest capture", 32'h3333, d);
        rreg(tcc_pkg::ADDR_STS);
        chk("over kept", 32'h2, d);
        wreg(tcc_pkg::ADDR_STS, 32'h2);
        rreg(tcc_pkg::ADDR_STS);
        chk("write one keeps", 32'h2, d);
        wreg(tcc_pkg::ADDR_STS, 32'h0);
        rreg(tcc_pkg::ADDR_STS);
        chk("write zero clears", 32'h0, d);
        // falling edge, requests off
        @(posedge i_mclk) cnt <= 16'h4444;
        wreg(tcc_pkg::ADDR_CTRL, ctl(tcc_pkg::DIR_OWN, tcc_pkg::FLT_LAST_SHORT, tcc_pkg::MODE_FROZEN, 5'h06));
        k = dma_cnt;
        lvl_to(1'b0);
        chk("no irq", 32'h0, {31'h0, irq});
        chk("no dma", 32'(k), 32'(dma_cnt));
        rreg(tcc_pkg::ADDR_VALUE);
        chk("falling capture", 32'h4444, d);
        // capture disabled
        wreg(tcc_pkg::ADDR_CTRL, ctl(tcc_pkg::DIR_OWN, tcc_pkg::FLT_LAST_SHORT, tcc_pkg::MODE_FROZEN, 5'h00));
        @(posedge i_mclk) cnt <= 16'h5555;
        lvl_to(1'b1);
        lvl_to(1'b0);
        rreg(tcc_pkg::ADDR_STS);
        chk("disabled", 32'h0, d);
        // neighbour input: own pin ignored, neighbour edge captured
        wreg(tcc_pkg::ADDR_CTRL, ctl(tcc_pkg::DIR_NEIGHBOUR, tcc_pkg::FLT_NONE, tcc_pkg::MODE_FROZEN, 5'h04));
        @(posedge i_mclk) cnt <= 16'h6666;
        lvl_to(1'b1);
        rreg(tcc_pkg::ADDR_STS);
        chk("own pin ignored", 32'h0, d);
        @(posedge i_mclk) nb_lvl <= 1'b1;
        settle(20);
        rreg(tcc_pkg::ADDR_VALUE);
        chk("neighbour capture", 32'h6666, d);
        // reset in mid-run
        @(posedge i_mclk) i_nrst <= 1'b0;
        settle(3);
        @(posedge i_mclk) i_nrst <= 1'b1;
        rreg(tcc_pkg::ADDR_CTRL);
        chk("ctrl after reset", {15'h0, tcc_pkg::CTL_RESET}, d);
        // divider every second edge: first edge skipped, second captured
        wreg(tcc_pkg::ADDR_CTRL, ctl(tcc_pkg::DIR_OWN, tcc_pkg::FLT_NONE, tcc_pkg::MODE_FROZEN, 5'h04) | 32'h40);
        lvl_to(1'b0);
        lvl_to(1'b1);
        rreg(tcc_pkg::ADDR_STS);
        chk("divided skip", 32'h0, d);
        lvl_to(1'b0);
        lvl_to(1'b1);
        rreg(tcc_pkg::ADDR_STS);
        chk("divided hit", 32'h1, d);
        end_sim();
    end
endmodule // tcc_channel_tb_top

// ### tcc_pkg.sv
// Operation
// R1 - each input is sampled, filtered, edge detected by polarity, offered as trigger; the code offers the trigger edge only on channels 1 and 2
// R2 - captures come only from divided events of the capture input
// R3 - reference is active high; polarity applied only at the final output stage
// R4 - software reaches the preload copy; captures go shadow first, then preload
// R5 - compare mode copies preload into shadow; only shadow is compared with counter
// R6 - a capture latches the counter, sets event flag, requests irq or dma
// R7 - event flag clears by software write or by reading the channel value
// R8 - overcapture set on capture while event flag set; cleared only by writing zero
// R9 - direction 01 uses own input, 10 uses the neighbouring channel input
// R10 - filter setting picks rate and length; code 0011 needs 8 samples
// R11 - polarity 0 selects rising edge, 1 selects falling edge
// R12 - divider 00 captures every valid edge; captures only while capture enable is one
// R13 - dma request only with dma enable, interrupt only with interrupt enable
// R14 - pwm input: two captures share one input on opposite edges, reset slave mode
// R15 - pwm input measurement only on channels one and two
// R16 - output mode: compare mode 101 forces reference high, 100 forces it low
// R17 - while forced, compares still set the flag and requests, reference unaffected
// R18 - on match: 000 keeps level, 010 drives inactive, 011 toggles
// R19 - match sets event flag, irq if enabled, dma if enabled and selected
// R20 - preload off: writes act at once; on: shadow updates at update event
// R21 - modes 110 and 111 are pwm 1 and 2 with alignment from alignment select
// R22 - pwm always compares; preload moves to shadow only on update events; with preload off the code copies it at once, as in R20
// R23 - pwm 1 up: high while counter below value; above reload stays high
// R24 - compare mode 001 drives the reference active on a match
package tcc_pkg;
    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STS = 4'h4;
    localparam logic [3:0] ADDR_VALUE = 4'h8;
    // ------------------------------------------------------------
    // control and status register fields
    // ------------------------------------------------------------
    localparam int CTL_DIR_LSB = 0;
    localparam int CTL_FLT_LSB = 2;
    localparam int CTL_DIV_LSB = 6;
    localparam int CTL_MODE_LSB = 8;
    localparam int CTL_PRELOAD = 11;
    localparam int CTL_POLARITY = 12;
    localparam int CTL_ENABLE = 13;
    localparam int CTL_IRQ_EN = 14;
    localparam int CTL_DMA_EN = 15;
    localparam int CTL_DMA_SEL = 16;
    localparam int CTL_WIDTH = 17;
    localparam int STS_EVENT = 0;
    localparam int STS_OVER = 1;
    localparam logic [CTL_WIDTH-1:0] CTL_RESET = 17'h00000;
    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] DIR_OUTPUT = 2'h0;
    localparam logic [1:0] DIR_OWN = 2'h1;
    localparam logic [1:0] DIR_NEIGHBOUR = 2'h2;
    localparam logic [2:0] MODE_FROZEN = 3'h0;
    localparam logic [2:0] MODE_ACTIVE = 3'h1;
    localparam logic [2:0] MODE_INACTIVE = 3'h2;
    localparam logic [2:0] MODE_TOGGLE = 3'h3;
    localparam logic [2:0] MODE_FORCE_LOW = 3'h4;
    localparam logic [2:0] MODE_FORCE_HIGH = 3'h5;
    localparam logic [2:0] MODE_PWM1 = 3'h6;
    localparam logic [2:0] MODE_PWM2 = 3'h7;
    localparam logic [1:0] ALIGN_EDGE = 2'h0;
    localparam logic [1:0] ALIGN_DOWN = 2'h1;
    localparam logic [1:0] ALIGN_UP = 2'h2;
    localparam logic [3:0] FLT_NONE = 4'h0;
    localparam logic [3:0] FLT_LAST_SHORT = 4'h3;
    localparam logic [3:0] FLT_LONG_LEN = 4'h8;
    localparam logic [3:0] FLT_BASE_DIV = 4'h2;
endpackage

// ### tcc_signal_src.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// far side: timer input source and neighbour filtered line
// ------------------------------------------------------------
module tcc_signal_src (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_level,
    input wire logic i_nb_level,
    input wire logic [7:0] i_glitch_len,
    output logic o_timer_input_pin,
    output logic o_neighbour_filtered
);
    logic [7:0] glitch_cnt_reg;
    // a glitch inverts the pin for a set number of cycles, then the level returns
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            glitch_cnt_reg <= 8'h00;
            o_neighbour_filtered <= 1'b0;
        end else begin
            glitch_cnt_reg <= (i_glitch_len != 8'h00) ? i_glitch_len : glitch_cnt_reg - {7'h00, glitch_cnt_reg != 8'h00};
            o_neighbour_filtered <= i_nb_level;
        end
    end
    // pin level seen by the channel
    assign o_timer_input_pin = i_level ^ (glitch_cnt_reg != 8'h00);
endmodule // tcc_signal_src
